// file: rf_front_model.sv
// RF front end model: counts carrier-on cycles, samples data mid-bit,
// drives fault detectors and power-on reset. Bit period is BITC cycles.
module rf_front_model #(
  parameter BITC = 4
) (
  input  wire logic        ref_clk,
  input  wire logic        rfOn,
  input  wire logic        rfData,
  input  wire logic [1:0]  faultSel,
  input  wire logic        porReq,
  output wire logic        lockTimeout,
  output wire logic        lockLost,
  output wire logic        xtalFail,
  output wire logic        rfPowerOnReset,
  output logic      [15:0] onCycles,
  output logic      [7:0]  rxBits,
  output logic      [7:0]  tailOnes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic onPrev = 1'b0;
  assign lockTimeout = (faultSel == 2'h1);
  assign lockLost = (faultSel == 2'h2);
  assign xtalFail = (faultSel == 2'h3);
  assign rfPowerOnReset = porReq;
  initial onCycles = 16'h0000;
  initial rxBits = 8'h00;
  initial tailOnes = 8'h00;
  always @(posedge ref_clk) begin
    onPrev <= rfOn;
    if (rfOn && !onPrev) begin
      onCycles <= 16'h0001;
      tailOnes <= 8'h00;
    end else if (rfOn) begin
      onCycles <= onCycles + 16'h0001;
      // Data-one cycles after the eight sampled bits
      if (onCycles >= 8 * BITC && rfData) begin
        tailOnes <= tailOnes + 8'h01;
      end
      // Mid-bit sample of the first eight bits
      if (onCycles % BITC == 1 && onCycles < 8 * BITC) begin
        rxBits <= {rxBits[6:0], rfData};
      end
    end
  end
endmodule

// file: rf_sync2.v
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit is a slow level from outside the ref_clk domain.
module rf_sync2 #(
  parameter W = 4
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);

  reg [W-1:0] stage1_q;
  reg [W-1:0] stage2_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= {W{1'b0}};
      stage2_q <= {W{1'b0}};
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule

// file: rf_transmit_control.v
// RF transmit control register block with data buffer window, paged
// register bank, interrupt status and a bit serializer.
// Assumes a classic Wishbone master on ref_clk and asynchronous pins
// for the RF power-on reset and the three fault detectors.
//
// Contract
// - Setting go bit 7 starts sending buffer data for the frame length.
// - Go clears by hardware at transmission end and on RF module reset.
// - Writing zero to go aborts the transmission in progress.
// - Page bit 6 maps the 16-byte window to lower or upper buffer half.
// - Page bit also switches lower/upper bank at indices 0x38 to 0x3B.
// - Page bit is cleared by system reset only, not RF module reset.
// - End-marker bit 5 appends two data-one bit periods per datagram.
// - End-marker bit is forced to zero by RF module reset.
// - Power field bits 4:0 resets to zero; zero means low power level.
// - Nonzero power codes step output level upward by half a decibel.
// - Frame carries length field plus one bits; zero sends nothing.
// - RF module reset from power-on pin or soft bit; buffer kept.
// - Go clearing at transmission end sets done flag and interrupt.
// - Fault stops RF output, clears go, sets the error flag.
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`include "tx_ctrl_map.vh"

module rf_transmit_control #(
  parameter BIT_CYCLES = `BIT_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        rfPowerOnReset,
  input  wire        lockTimeout,
  input  wire        lockLost,
  input  wire        xtalFail,
  output wire        rfOn,
  output wire        rfData,
  output wire [4:0]  ampPowerLevel,
  output wire        irq
);

  localparam [15:0] RATE_RST = BIT_CYCLES[15:0];

  // Byte write with lane enable
  function [7:0] laneByte;
    input [7:0] oldVal;
    input [7:0] newVal;
    input       laneEn;
    begin
      laneByte = laneEn ? newVal : oldVal;
    end
  endfunction

  // Write strobe for one register offset
  function wrHit;
    input [7:0] adr;
    input [7:0] offset;
    input       strobe;
    begin
      wrHit = strobe & (adr == offset);
    end
  endfunction

  // Buffer and paged bank storage
  reg [7:0] buffer [0:31];
  reg [7:0] bank   [0:7];

  // Registers
  reg        go_q;
  reg        page_q;
  reg        eom_q;
  reg [4:0]  pwr_q;
  reg [7:0]  frame_q;
  reg [15:0] rate_q;
  reg        softRst_q;
  reg [1:0]  status_q;
  reg [1:0]  mask_q;
  reg        ack_q;
  reg [31:0] rdData_q;
  reg        rfOn_q;
  reg        irq_q;

  reg        go_d;
  reg [1:0]  status_d;
  reg [31:0] rdData_d;

  // Synchronised pins
  wire [3:0] pinSync;
  wire       porSync;
  wire       faultSync;

  rf_sync2 #(
    .W (4)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .asyncIn ({xtalFail, lockLost, lockTimeout, rfPowerOnReset}),
    .syncOut (pinSync)
  );

  assign porSync   = pinSync[0];
  assign faultSync = |pinSync[3:1];

  // RF module reset; the buffer never sees it
  wire rfRst = porSync | softRst_q;

  // Bus decode
  wire       req     = wb_cyc_i & wb_stb_i;
  wire       wrEn    = req & wb_we_i & ack_q & wb_sel_i[0];
  wire [7:0] wrByte  = wb_dat_i[7:0];
  wire       hitCtrl = (wb_adr_i == `REG_CTRL);
  wire       hitWin  = ((wb_adr_i & `WIN_MASK) == `WIN_BASE);
  wire [7:0] bankLo  = `BANK_IDX_LO << 2;
  wire       hitBank = ((wb_adr_i & `BANK_MASK) == bankLo);
  wire [4:0] winIdx  = {page_q, wb_adr_i[5:2]};
  wire [2:0] bankIdx = {page_q, wb_adr_i[3:2]};
  wire       wrCtrl  = wrEn & hitCtrl;
  wire       wrFrame   = wrHit(wb_adr_i, `REG_FRAME, wrEn);
  wire       wrRate    = wrHit(wb_adr_i, `REG_RATE, wrEn);
  wire       wrRfReset = wrHit(wb_adr_i, `REG_RFRESET, wrEn);
  wire       wrStatus  = wrHit(wb_adr_i, `REG_STATUS, wrEn);
  wire       wrMask    = wrHit(wb_adr_i, `REG_MASK, wrEn);

  // Serializer
  wire [7:0] bitIndex;
  wire       txBusy;
  wire       txData;
  wire       txFinished;
  wire       bitValue;
  wire       faultEvent;
  wire       swAbort;
  wire       txStart;
  wire       txAbort;

  assign bitValue   = buffer[bitIndex[7:3]][3'd7 - bitIndex[2:0]];
  assign faultEvent = faultSync & go_q;
  assign swAbort    = wrCtrl & ~wrByte[`GO_BIT] & go_q;
  assign txStart    = wrCtrl & wrByte[`GO_BIT] & ~go_q & ~rfRst;
  assign txAbort    = swAbort | faultEvent;

  tx_serializer u_ser (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clear     (rfRst),
    .start     (txStart),
    .abort     (txAbort),
    .frameLen  (frame_q),
    .eomEn     (eom_q),
    .bitCycles (rate_q),
    .bitValue  (bitValue),
    .bitIndex  (bitIndex),
    .busy      (txBusy),
    .txData    (txData),
    .finished  (txFinished)
  );

  // Go bit next value
  always @* begin
    go_d = go_q;
    if (wrCtrl)
      go_d = wrByte[`GO_BIT];
    if (txFinished)
      go_d = 1'b0;
    if (faultEvent)
      go_d = 1'b0;
    if (rfRst)
      go_d = 1'b0;
  end

  // Sticky flags: hardware set wins over write-one clear
  always @* begin
    status_d = status_q;
    if (wrStatus)
      status_d = status_q & ~wrByte[1:0];
    if (txFinished && go_q)
      status_d[`DONE_BIT] = 1'b1;
    if (faultEvent)
      status_d[`ERR_BIT] = 1'b1;
  end

  // Read mux
  always @* begin
    rdData_d = 32'h0000_0000;
    if (hitWin)
      rdData_d[7:0] = buffer[winIdx];
    else if (hitBank)
      rdData_d[7:0] = bank[bankIdx];
    else begin
      case (wb_adr_i)
        `REG_CTRL:    rdData_d[7:0] = {go_q, page_q, eom_q, pwr_q};
        `REG_FRAME:   rdData_d[7:0] = frame_q;
        `REG_RATE:    rdData_d[15:0] = rate_q;
        `REG_STATUS:  rdData_d[1:0] = status_q;
        `REG_MASK:    rdData_d[1:0] = mask_q;
        default:      rdData_d = 32'h0000_0000;
      endcase
    end
  end

  // Bus handshake: ack one cycle after the request, dropped next cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q    <= 1'b0;
      rdData_q <= 32'h0000_0000;
    end else begin
      ack_q    <= req & ~ack_q;
      rdData_q <= rdData_d;
    end
  end

  // Page bit tracks system reset only
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      page_q <= 1'b0;
    else if (wrCtrl)
      page_q <= wrByte[`PAGE_BIT];
  end

  // RF module registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      go_q   <= 1'b0;
      eom_q  <= 1'b0;
      pwr_q  <= 5'h00;
      frame_q <= `FRAME_RST;
      rate_q <= RATE_RST;
    end else begin
      go_q <= go_d;
      if (rfRst) begin
        eom_q   <= 1'b0;
        pwr_q   <= 5'h00;
        frame_q <= `FRAME_RST;
        rate_q  <= RATE_RST;
      end else begin
        if (wrCtrl) begin
          eom_q <= wrByte[`EOM_BIT];
          pwr_q <= wrByte[`PWR_MSB:0];
        end
        if (wrFrame)
          frame_q <= wrByte;
        if (wrRate)
          rate_q <= {laneByte(rate_q[15:8], wb_dat_i[15:8], wb_sel_i[1]),
                     wrByte};
      end
    end
  end

  // Soft RF reset pulse, status, mask, output stage
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      softRst_q <= 1'b0;
      status_q  <= `STATUS_RST;
      mask_q    <= `MASK_RST;
      rfOn_q    <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      softRst_q <= wrRfReset & wrByte[0];
      status_q  <= status_d;
      if (wrMask)
        mask_q <= wrByte[1:0];
      rfOn_q <= txBusy & ~txAbort & ~rfRst;
      irq_q  <= |(status_q & mask_q);
    end
  end

  // Buffer and bank writes; no reset so RF reset leaves contents alone
  always @(posedge ref_clk) begin
    if (wrEn && hitWin)
      buffer[winIdx] <= wrByte;
    if (wrEn && hitBank)
      bank[bankIdx] <= wrByte;
  end

  assign wb_ack_o      = ack_q;
  assign wb_dat_o      = rdData_q;
  assign rfOn          = rfOn_q;
  assign rfData        = txData;
  assign ampPowerLevel = pwr_q;
  assign irq           = irq_q;

endmodule

// file: rf_transmit_control_props.sv
// Port checker for the RF transmit control block.
// Assumes classic Wishbone on ref_clk and rst_n as reset.
`include "tx_ctrl_map.vh"
module rf_transmit_control_props #(
  parameter BIT_CYCLES = 4
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        rfPowerOnReset,
  input wire logic        lockTimeout,
  input wire logic        lockLost,
  input wire logic        xtalFail,
  input wire logic        rfOn,
  input wire logic        rfData,
  input wire logic [4:0]  ampPowerLevel,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire wrAck = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire fault = lockTimeout | lockLost | xtalFail;
  wire ctrlWr = wrAck & (wb_adr_i == `REG_CTRL);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_power_write: assert property (
    ctrlWr |=> ampPowerLevel == $past(wb_dat_i[4:0]))
    else $error("power field not written");
  a_power_por: assert property (
    $rose(rfPowerOnReset) |-> ##[1:4] ampPowerLevel == 5'h00)
    else $error("power not cleared by power-on reset");
  a_soft_reset: assert property (
    wrAck && wb_adr_i == `REG_RFRESET && wb_dat_i[0]
      |-> ##[1:3] ampPowerLevel == 5'h00)
    else $error("power not cleared by soft reset");
  a_fault_off: assert property ($rose(fault) |-> ##[1:5] !rfOn)
    else $error("output on after fault");
  a_abort_off: assert property (
    ctrlWr && !wb_dat_i[`GO_BIT] |-> ##[1:3] !rfOn)
    else $error("output on after abort");
  a_idle_data: assert property (!rfOn ##1 !rfOn |-> !rfData)
    else $error("data active while idle");
  a_irq_masked: assert property (
    wrAck && wb_adr_i == `REG_MASK && wb_dat_i[1:0] == 2'h0
      |-> ##[1:2] !irq)
    else $error("irq high while masked");
  c_done: cover property ($fell(rfOn) ##[1:4] irq);
  c_fault: cover property ($rose(fault) && rfOn);
  c_start: cover property (ctrlWr && wb_dat_i[`GO_BIT]);
endmodule
bind rf_transmit_control rf_transmit_control_props #(
  .BIT_CYCLES(BIT_CYCLES)) u_props (.ref_clk, .rst_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .rfPowerOnReset, .lockTimeout, .lockLost, .xtalFail,
  .rfOn, .rfData, .ampPowerLevel, .irq);

// file: rf_transmit_control_tb.sv
// Self-checking bench for the RF transmit control block.
// Assumes the RF front end model and the port checker beside it.
`include "tx_ctrl_map.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module rf_transmit_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam BITC = 4;
  logic ref_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0;
  logic [1:0] faultSel = 0;
  logic porReq = 0;
  wire [31:0] wb_dat_o;
  wire [4:0] ampPowerLevel;
  wire [15:0] onCycles;
  wire [7:0] rxBits, tailOnes;
  wire wb_ack_o, rfPowerOnReset, lockTimeout, lockLost, xtalFail;
  wire rfOn, rfData, irq;
  int n_errors = 0, checked = 0, i;
  logic [31:0] expQ[$];
  logic [7:0] b0, b1, pw;
  logic [15:0] oc;
  logic [31:0] expRd;

  rf_transmit_control #(.BIT_CYCLES(BITC)) u_dut (.ref_clk, .rst_n,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .rfPowerOnReset, .lockTimeout, .lockLost,
    .xtalFail, .rfOn, .rfData, .ampPowerLevel, .irq);
  rf_front_model #(.BITC(BITC)) u_front (.ref_clk, .rfOn, .rfData,
    .faultSel, .porReq, .lockTimeout, .lockLost, .xtalFail,
    .rfPowerOnReset, .onCycles, .rxBits, .tailOnes);

  initial forever #5 ref_clk = ~ref_clk;

  task final_report;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic bus(input [7:0] a, input [7:0] d, input w);
    int n;
    n = 0;
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w;
    wb_adr_i <= a; wb_sel_i <= 4'h1; wb_dat_i <= {24'h00_0000, d};
    do begin @(posedge ref_clk); n++; end while (!wb_ack_o && n < 50);
    if (!wb_ack_o) begin n_errors++; final_report(); end
    wb_cyc_i <= 0; wb_stb_i <= 0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input [7:0] a, input [7:0] d);
    bus(a, d, 1);
  endtask
  task automatic rd(input [7:0] a, input [7:0] e);
    expQ.push_back({24'h00_0000, e});
    bus(a, 8'h00, 0);
  endtask
  task automatic waitIrq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin @(posedge ref_clk); n++; end
  endtask

  // Read results against the oldest note
  always @(posedge ref_clk) begin
    if (wb_ack_o && !wb_we_i) begin
      expRd = expQ.pop_front();
      `CHK("read", expRd, wb_dat_o)
    end
  end

  initial begin
    #(30000 * 10);
    n_errors++;
    final_report();
  end

  initial begin
    void'($urandom(32'h9d85));
    b0 = $urandom; b1 = $urandom; pw = $urandom % 21;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    rd(`REG_CTRL, 8'h00);
    rd(8'h30, 8'h00);
    rd(`REG_RATE, BITC);
    wr(`WIN_BASE, b0); wr(8'hE0, b0 ^ 8'h5a);
    wr(`REG_CTRL, 8'h40); wr(`WIN_BASE, b1); wr(8'hE0, b1);
    rd(`WIN_BASE, b1); rd(8'hE0, b1);
    wr(`REG_CTRL, 8'h00);
    rd(`WIN_BASE, b0); rd(8'hE0, b0 ^ 8'h5a);
    wr(`REG_MASK, 8'h03); wr(`REG_FRAME, 8'h07);
    for (i = 0; i < 2; i++) begin
      wr(`REG_CTRL, 8'h80 | (i ? 8'h00 : 8'h20) | pw);
      waitIrq();
      `CHK("bits", b0, rxBits)
      `CHK("span", i ? 16'h0020 : 16'h0028, onCycles)
      `CHK("tail", i ? 8'h00 : 8'(`EOM_BITS * BITC), tailOnes)
      `CHK("irq", 1'b1, irq)
      `CHK("amp", pw[4:0], ampPowerLevel)
      rd(`REG_STATUS, 8'h01);
      rd(`REG_CTRL, (i ? 8'h00 : 8'h20) | pw);
      wr(`REG_MASK, 8'h00);
      @(posedge ref_clk);
      `CHK("masked", 1'b0, irq)
      wr(`REG_STATUS, 8'h01); rd(`REG_STATUS, 8'h00); wr(`REG_MASK, 8'h03);
    end
    oc = onCycles;
    wr(`REG_FRAME, 8'h00); wr(`REG_CTRL, 8'h80);
    waitIrq();
    `CHK("none", oc, onCycles)
    rd(`REG_STATUS, 8'h01); wr(`REG_STATUS, 8'h01);
    wr(`REG_FRAME, 8'hff); wr(`REG_CTRL, 8'h80);
    repeat (10) @(posedge ref_clk);
    wr(`REG_CTRL, 8'h00);
    repeat (2) @(posedge ref_clk);
    `CHK("abort", 1'b0, rfOn)
    rd(`REG_STATUS, 8'h00);
    for (i = 1; i < 4; i++) begin
      wr(`REG_CTRL, 8'h80);
      repeat (10) @(posedge ref_clk);
      faultSel <= i[1:0];
      repeat (6) @(posedge ref_clk);
      `CHK("fault", 1'b0, rfOn)
      faultSel <= 0;
      rd(`REG_STATUS, 8'h02); rd(`REG_CTRL, 8'h00);
      wr(`REG_STATUS, 8'h02);
    end
    wr(`REG_CTRL, 8'h60 | pw);
    porReq <= 1;
    repeat (4) @(posedge ref_clk);
    porReq <= 0;
    repeat (3) @(posedge ref_clk);
    rd(`REG_CTRL, 8'h40); rd(`WIN_BASE, b1);
    rd(`REG_FRAME, 8'h00);
    wr(`REG_CTRL, 8'h7f); wr(`REG_RFRESET, 8'h01);
    rd(`REG_CTRL, 8'h40);
    rst_n <= 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    rd(`REG_CTRL, 8'h00);
    final_report();
  end
endmodule

// file: tx_ctrl_map.vh
// Register map, field positions, reset values and timing for the RF
// transmit control block. Definitions only; included by bare name.
`ifndef TX_CTRL_MAP_VH
`define TX_CTRL_MAP_VH

// Byte offsets on the register bus
`define REG_CTRL       8'h00
`define REG_FRAME      8'h04
`define REG_RATE       8'h08
`define REG_RFRESET    8'h0C
`define REG_STATUS     8'h10
`define REG_MASK       8'h14
`define WIN_BASE       8'h40
`define WIN_MASK       8'hC0
// Paged bank: register indices, byte address is four times the index
`define BANK_IDX_LO    8'h38
`define BANK_IDX_HI    8'h3B
`define BANK_MASK      8'hF0

// Control register fields
`define GO_BIT         7
`define PAGE_BIT       6
`define EOM_BIT        5
`define PWR_MSB        4

// Status and mask fields
`define DONE_BIT       0
`define ERR_BIT        1

// Reset values
`define CTRL_RST       8'h00
`define FRAME_RST      8'h00
`define STATUS_RST     2'h0
`define MASK_RST       2'h0

// Timing
`define EOM_BITS       2
`define CLK_PERIOD_NS  10
`define BIT_TIME_NS    104167

`endif

// file: tx_serializer.v
// Bit serializer: sends frameLen+1 buffer bits, then an optional tail; frameLen zero sends nothing.
// Assumes the caller supplies bitValue for bitIndex in the same cycle.
module tx_serializer (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        clear,
  input  wire        start,
  input  wire        abort,
  input  wire [7:0]  frameLen,
  input  wire        eomEn,
  input  wire [15:0] bitCycles,
  input  wire        bitValue,
  output wire [7:0]  bitIndex,
  output wire        busy,
  output wire        txData,
  output wire        finished
);

  localparam IDLE = 2'd0;
  localparam DATA = 2'd1;
  localparam TAIL = 2'd2;

  reg [1:0]  state_q;
  reg [15:0] divCnt_q;
  reg [7:0]  idx_q;
  reg [1:0]  tailCnt_q;
  reg        data_q;
  reg        fin_q;
  wire       tick;
  wire [15:0] lastCnt;

  assign lastCnt = (bitCycles == 16'h0000) ? 16'h0000 : bitCycles - 16'h0001;
  assign tick    = (divCnt_q == lastCnt);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= IDLE;
      divCnt_q  <= 16'h0000;
      idx_q     <= 8'h00;
      tailCnt_q <= 2'd0;
      data_q    <= 1'b0;
      fin_q     <= 1'b0;
    end else begin
      fin_q  <= 1'b0;
      divCnt_q <= (state_q == IDLE || tick) ? 16'h0000 : divCnt_q + 16'h0001;
      case (state_q)
        IDLE: begin
          data_q <= 1'b0;
          idx_q  <= 8'h00;
          if (start && !clear && !abort) begin
            if (frameLen == 8'h00)
              fin_q <= 1'b1;            // Nothing sent
            else
              state_q <= DATA;
          end
        end
        DATA: begin
          data_q <= bitValue;
          if (tick) begin
            if (idx_q == frameLen) begin  // Length plus one bits
              if (eomEn) begin
                state_q   <= TAIL;
                tailCnt_q <= 2'd0;
              end else begin
                state_q <= IDLE;
                fin_q   <= 1'b1;
              end
            end else begin
              idx_q <= idx_q + 8'h01;
            end
          end
        end
        TAIL: begin
          data_q <= 1'b1;                 // Data-one carrier state
          if (tick) begin
            if ({30'd0, tailCnt_q} == `EOM_BITS - 1) begin
              state_q <= IDLE;
              fin_q   <= 1'b1;
            end else begin
              tailCnt_q <= tailCnt_q + 2'd1;
            end
          end
        end
        default: state_q <= IDLE;
      endcase
      if (clear || abort) begin           // Stop at once
        state_q <= IDLE;
        data_q  <= 1'b0;
        fin_q   <= 1'b0;
      end
    end
  end

  assign bitIndex = idx_q;
  assign busy     = (state_q != IDLE);
  assign txData   = data_q;
  assign finished = fin_q;

endmodule
